// ==== mrd_regs.svh ====
// Constants for the mode register two/three decode block.
// Assumes inclusion by both ends; definitions only.
`ifndef MRD_REGS_SVH
`define MRD_REGS_SVH
`define MRD_BA_MR2 3'h2
`define MRD_BA_MR3 3'h3
`define MRD_MR2_PARTIAL_ARRAY_RETENTION_LSB 0
`define MRD_MR2_CWD_LSB 3
`define MRD_MR2_SRT_BIT 7
`define MRD_MR2_RTTWR_LSB 9
`define MRD_MR3_LOC_LSB 0
`define MRD_MR3_MPR_BIT 2
`define MRD_MR2_RSV_MASK 13'h1940
`define MRD_MR3_RSV_MASK 13'h1ff8
`define MRD_MR2_RESET 13'h0000
`define MRD_MR3_RESET 13'h0000
`define MRD_LINK_DIV 8'h04
`define MRD_REFRESH_NORM_MS 64
`define MRD_REFRESH_HOT_MS 32
`define MRD_MPR_PATTERN 8'h55
`endif

// ==== mrd_pkg.sv ====
// Types shared by both ends of the mode register decode link.
// Assumes mrd_regs.svh is on the include path.
package mrd_pkg;
    typedef enum logic [2:0] {
        MRD_RTT_OFF = 3'h1,
        MRD_RTT_QUARTER = 3'h2,
        MRD_RTT_HALF = 3'h4
    } mrd_rtt_type;
    typedef enum logic [2:0] {
        MRD_IDLE = 3'h1,
        MRD_SETUP = 3'h2,
        MRD_HOLD = 3'h4
    } mrd_host_state_type;
endpackage

// ==== mrd_link_if.sv ====
// Command/address link between controller and memory device.
// Assumes both ends share one system clock for their logic.
interface mrd_link_if;
    logic linkClk;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [2:0] bankAddr;
    logic [12:0] addr;
    modport device (input linkClk, csN, rasN, casN, weN, bankAddr, addr);
    modport host (output linkClk, csN, rasN, casN, weN, bankAddr, addr);
endinterface

// ==== mrd_device.sv ====
// Device end: samples mode register set commands on the link clock
// edge and decodes mode registers two and three.
// Assumes link pins are asynchronous to clk_sys and are synchronised here.
//
// Contract
// R01: Termination from A10:A9, quarter or half.
// R02: Code 00 switches dynamic termination off.
// R03: Write CAS delay from A5:A3 table.
// R04: Write CAS delay counts whole cycles.
// R05: Every latency is an integer count.
// R06: Total write delay is added plus CAS.
// R07: Bit 7 doubles self-refresh rate.
// R08: Controller halves refresh period when hot.
// R09: When hot, set bit 7 or skip self-refresh.
// R10: Partial retention drops banks outside range.
// R11: Controller zeroes reserved bits of register two.
// R12: Write termination works with nominal disabled.
// R13: Write leveling keeps only nominal termination.
// R14: Termination switches for writes by itself.
// R15: Register two uses bank address 010.
// R16: Register three uses bank address 011.
// R17: Controller zeroes reserved bits of register three.
// R18: Location ignored in normal mode.
// R19: Readout returns fixed pattern for reads.
// R20: Controller avoids reserved codes.
//
// Decided for this implementation: the register offsets.
module mrd_device
    import mrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    mrd_link_if.device link,
    input wire logic [1:0] addedLatency,
    input wire logic nomTermEnable,
    input wire logic writeLeveling,
    input wire logic writeBurst,
    input wire logic selfRefresh,
    output logic [3:0] writeCasDelay,
    output logic [4:0] totalWriteDelay,
    output logic latencyReserved,
    output logic [2:0] termSelect,
    output logic termReserved,
    output logic doubleRefresh,
    output logic [7:0] retainedBanks,
    output logic readoutEnable,
    output logic [1:0] readoutLocation,
    output logic [7:0] readoutPattern
);
`include "mrd_regs.svh"
    typedef struct packed {
        logic [20:0] sync1;
        logic [20:0] sync2;
        logic clkPrev;
        logic [12:0] modeTwo;
        logic [12:0] modeThree;
        logic [3:0] cwd;
        logic [4:0] twd;
        logic latRsv;
        logic [2:0] term;
        logic termRsv;
        logic dbl;
        logic [7:0] keep;
        logic rdEn;
        logic [1:0] rdLoc;
        logic [7:0] rdPat;
    } mrd_dev_state_type;

    mrd_dev_state_type s_q;
    mrd_dev_state_type s_d;
    logic [20:0] pinsNow;
    logic clkNow;
    logic isMrs;
    logic [3:0] cmdNow;
    logic [2:0] ba;
    logic [12:0] a;
    logic [12:0] m2;

    // Every pin passes the same two stages, so the command lines are seen
    // in the same cycle as the link clock edge that they belong to.
    assign pinsNow = {link.linkClk, link.csN, link.rasN, link.casN,
                      link.weN, link.bankAddr, link.addr};

    // A set command: all four command lines low and the bank matches.
    function automatic logic cmdFor(input logic [3:0] lines,
            input logic [2:0] bankNow, input logic [2:0] bankWant);
        cmdFor = (lines == 4'h0) && (bankNow == bankWant);
    endfunction

    // Integer cycles only; a result of 0 stands for a reserved code.
    function automatic logic [3:0] cwdDecode(input logic [2:0] code);
        unique case (code)
            3'h0: cwdDecode = 4'h5; // R03
            3'h1: cwdDecode = 4'h6;
            3'h2: cwdDecode = 4'h7;
            3'h3: cwdDecode = 4'h8;
            3'h4: cwdDecode = 4'h9;
            3'h5: cwdDecode = 4'h0;
            3'h6: cwdDecode = 4'h0;
            3'h7: cwdDecode = 4'h0;
        endcase
    endfunction

    // Banks kept through self refresh, one bit per bank.
    function automatic logic [7:0] keepDecode(input logic [2:0] code);
        unique case (code)
            3'h0: keepDecode = 8'hff;
            3'h1: keepDecode = 8'h0f;
            3'h2: keepDecode = 8'h03;
            3'h3: keepDecode = 8'h01;
            3'h4: keepDecode = 8'hfc;
            3'h5: keepDecode = 8'hf0;
            3'h6: keepDecode = 8'hc0;
            3'h7: keepDecode = 8'h80;
        endcase
    endfunction

    // Termination in use: 0 is the nominal value, 1 off, 2 or 4 write.
    // Leveling wins over a write, so only the nominal value, or off with nominal disabled, is seen then.
    function automatic logic [2:0] termDecode(input logic [1:0] code,
            input logic burst, input logic level, input logic nomOn);
        logic [2:0] idle;
        idle = nomOn ? 3'h0 : MRD_RTT_OFF;
        termDecode = idle;
        if (burst && !level) begin // R13
            unique case (code)
                2'h1: termDecode = MRD_RTT_QUARTER; // R01
                2'h2: termDecode = MRD_RTT_HALF; // R01
                default: termDecode = idle; // R02
            endcase
        end
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.sync1 = pinsNow;
        s_d.sync2 = s_q.sync1;
        clkNow = s_q.sync2[20];
        cmdNow = s_q.sync2[19:16];
        ba = s_q.sync2[15:13];
        a = s_q.sync2[12:0];
        s_d.clkPrev = clkNow;

        // Commands are taken on the rising link clock edge only.
        isMrs = clkNow && !s_q.clkPrev;
        if (isMrs && cmdFor(cmdNow, ba, `MRD_BA_MR2)) begin // R15
            s_d.modeTwo = a;
        end
        if (isMrs && cmdFor(cmdNow, ba, `MRD_BA_MR3)) begin // R16
            s_d.modeThree = a;
        end

        m2 = s_q.modeTwo;
        s_d.cwd = cwdDecode(m2[`MRD_MR2_CWD_LSB +: 3]); // R04
        s_d.latRsv = (s_d.cwd == 4'h0);
        // Sum is kept in whole cycles; no half-cycle term exists.
        s_d.twd = 5'(s_d.cwd) + 5'(addedLatency); // R05 R06

        s_d.termRsv = (m2[`MRD_MR2_RTTWR_LSB +: 2] == 2'h3);
        // Nominal enable is not consulted for the write value.
        s_d.term = termDecode(m2[`MRD_MR2_RTTWR_LSB +: 2], writeBurst,
            writeLeveling, nomTermEnable); // R12 R14
        s_d.dbl = m2[`MRD_MR2_SRT_BIT]; // R07
        s_d.keep = 8'hff;
        if (selfRefresh) begin
            s_d.keep = keepDecode(m2[`MRD_MR2_PARTIAL_ARRAY_RETENTION_LSB +: 3]); // R10
        end

        s_d.rdEn = s_q.modeThree[`MRD_MR3_MPR_BIT]; // R19
        s_d.rdLoc = 2'h0;
        s_d.rdPat = 8'h00;
        if (s_d.rdEn) begin // R18
            s_d.rdLoc = s_q.modeThree[`MRD_MR3_LOC_LSB +: 2];
            s_d.rdPat = `MRD_MPR_PATTERN; // R19
        end

        // The link clock idles low, so clearing the stages adds no edge.
        if (!rst_n) begin
            s_d.sync1 = '0;
            s_d.sync2 = '0;
            s_d.clkPrev = 1'b0;
            s_d.modeTwo = `MRD_MR2_RESET;
            s_d.modeThree = `MRD_MR3_RESET;
            s_d.cwd = 4'h5;
            s_d.twd = 5'h05;
            s_d.latRsv = 1'b0;
            s_d.term = MRD_RTT_OFF;
            s_d.termRsv = 1'b0;
            s_d.dbl = 1'b0;
            s_d.keep = 8'hff;
            s_d.rdEn = 1'b0;
            s_d.rdLoc = 2'h0;
            s_d.rdPat = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign writeCasDelay = s_q.cwd;
    assign totalWriteDelay = s_q.twd;
    assign latencyReserved = s_q.latRsv;
    assign termSelect = s_q.term;
    assign termReserved = s_q.termRsv;
    assign doubleRefresh = s_q.dbl;
    assign retainedBanks = s_q.keep;
    assign readoutEnable = s_q.rdEn;
    assign readoutLocation = s_q.rdLoc;
    assign readoutPattern = s_q.rdPat;
endmodule

// ==== mrd_host.sv ====
// Controller end: issues mode register set commands on request and
// drives the link clock from clk_sys by a divider.
// Assumes the request inputs come from logic on clk_sys.
module mrd_host
    import mrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    mrd_link_if.host link,
    input wire logic setReq,
    input wire logic selectThree,
    input wire logic [12:0] fieldValue,
    input wire logic hotCase,
    output logic busy,
    output logic refreshHalved,
    output logic codeRefused
);
`include "mrd_regs.svh"
    typedef struct packed {
        mrd_host_state_type st;
        logic [7:0] div;
        logic lclk;
        logic [3:0] cmd;
        logic [2:0] ba;
        logic [12:0] a;
        logic busy;
        logic half;
        logic refused;
    } mrd_host_state_struct_type;

    mrd_host_state_struct_type s_q;
    mrd_host_state_struct_type s_d;
    logic tick;
    logic [12:0] val;
    logic bad;

    always_comb begin
        s_d = s_q;
        tick = (s_q.div == `MRD_LINK_DIV - 8'h01);
        s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
        if (tick) begin
            s_d.lclk = !s_q.lclk;
        end
        s_d.half = hotCase; // R08
        val = fieldValue;
        // Hot case forces the doubled self-refresh bit on.
        if (!selectThree) begin
            val = (fieldValue & ~`MRD_MR2_RSV_MASK) |
                (hotCase ? 13'h0080 : 13'h0000); // R09 R11
        end else begin
            val = fieldValue & ~`MRD_MR3_RSV_MASK; // R17
        end
        bad = !selectThree && (fieldValue[10:9] == 2'h3 ||
            fieldValue[5:3] > 3'h4); // R20
        unique case (s_q.st)
            MRD_IDLE: begin
                if (setReq) begin
                    s_d.refused = bad;
                    if (!bad) begin
                        s_d.st = MRD_SETUP;
                        s_d.busy = 1'b1;
                        s_d.cmd = 4'h0;
                        s_d.ba = selectThree ?
                            `MRD_BA_MR3 : `MRD_BA_MR2; // R15 R16
                        s_d.a = val;
                    end
                end
            end
            MRD_SETUP: begin
                if (tick && !s_q.lclk) begin
                    s_d.st = MRD_HOLD;
                end
            end
            MRD_HOLD: begin
                if (tick && !s_q.lclk) begin
                    s_d.st = MRD_IDLE;
                    s_d.busy = 1'b0;
                    s_d.cmd = 4'hf;
                end
            end
        endcase
        if (!rst_n) begin
            s_d = '0;
            s_d.st = MRD_IDLE;
            s_d.cmd = 4'hf;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign link.linkClk = s_q.lclk;
    assign {link.csN, link.rasN, link.casN, link.weN} = s_q.cmd;
    assign link.bankAddr = s_q.ba;
    assign link.addr = s_q.a;
    assign busy = s_q.busy;
    assign refreshHalved = s_q.half;
    assign codeRefused = s_q.refused;
endmodule

// ==== mrd_assertions.sv ====
// Checker for the command link between controller and device ends.
// Assumes the link signals are sampled on clk_sys.
module mrd_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic linkClk,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [2:0] bankAddr,
    input wire logic [12:0] addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic cmdOn;
    assign cmdOn = ~csN;
    sequence s_low8;
        (!csN) [*8];
    endsequence
    sequence s_high4;
        linkClk [*4] ##1 !linkClk;
    endsequence
    property p_mr2_rsv;
        cmdOn && bankAddr == 3'h2 |-> (addr & 13'h1940) == 13'h0000;
    endproperty
    property p_mr3_rsv;
        cmdOn && bankAddr == 3'h3 |-> (addr & 13'h1ff8) == 13'h0000;
    endproperty
    property p_codes;
        cmdOn && bankAddr == 3'h2 |-> addr[5:3] < 3'h5 && addr[10:9] != 2'h3;
    endproperty
    property p_bank; cmdOn |-> bankAddr inside {3'h2, 3'h3}; endproperty
    property p_lines; cmdOn |-> !rasN && !casN && !weN; endproperty
    property p_hold; $fell(csN) |-> s_low8; endproperty
    property p_stable;
        cmdOn && $past(cmdOn) |-> $stable(addr) && $stable(bankAddr);
    endproperty
    // The host counts on a fixed divider, so the high phase is exact.
    property p_clk; $rose(linkClk) |-> s_high4; endproperty
    a_mr2_rsv: assert property (p_mr2_rsv)
        else $error("reserved bits set in register two");
    a_mr3_rsv: assert property (p_mr3_rsv)
        else $error("reserved bits set in register three");
    a_codes: assert property (p_codes)
        else $error("reserved code sent");
    a_bank: assert property (p_bank)
        else $error("wrong bank address");
    a_lines: assert property (p_lines)
        else $error("command lines not all low");
    a_hold: assert property (p_hold)
        else $error("command released early");
    a_stable: assert property (p_stable)
        else $error("address moved during command");
    a_clk: assert property (p_clk)
        else $error("link clock high phase wrong");
endmodule

// ==== dram_mode_reg_two_three_decode_tb.sv ====
// Bench joining controller and device ends over the link.
// Assumes clk_sys at 25 MHz and the link divider of the designer.
module dram_mode_reg_two_three_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic setReq = 1'b0;
    logic selectThree = 1'b0;
    logic hotCase = 1'b0;
    logic [12:0] fieldValue = 13'h0000;
    logic [1:0] addedLatency = 2'h0;
    logic nomTermEnable = 1'b0;
    logic writeLeveling = 1'b0;
    logic writeBurst = 1'b1;
    logic selfRefresh = 1'b0;
    logic busy, refreshHalved, codeRefused, latencyReserved, termReserved;
    logic doubleRefresh, readoutEnable;
    logic [3:0] writeCasDelay;
    logic [4:0] totalWriteDelay;
    logic [2:0] termSelect;
    logic [7:0] retainedBanks, readoutPattern;
    logic [1:0] readoutLocation;
    logic [7:0] keepTab [8] = '{8'hff, 8'h0f, 8'h03, 8'h01,
        8'hfc, 8'hf0, 8'hc0, 8'h80};
    int bad_count = 0;
    int checks = 0;
    mrd_link_if link();
    mrd_host u_mrd_host (.clk_sys, .rst_n, .link(link), .setReq,
        .selectThree, .fieldValue, .hotCase, .busy, .refreshHalved,
        .codeRefused);
    mrd_device u_mrd_device (.clk_sys, .rst_n, .link(link), .addedLatency,
        .nomTermEnable, .writeLeveling, .writeBurst, .selfRefresh,
        .writeCasDelay, .totalWriteDelay, .latencyReserved, .termSelect,
        .termReserved, .doubleRefresh, .retainedBanks, .readoutEnable,
        .readoutLocation, .readoutPattern);
    mrd_assertions u_mrd_assertions (.clk_sys, .rst_n,
        .linkClk(link.linkClk), .csN(link.csN), .rasN(link.rasN),
        .casN(link.casN), .weN(link.weN), .bankAddr(link.bankAddr),
        .addr(link.addr));
    initial forever #20 clk_sys = ~clk_sys;
    function automatic logic [2:0] exp_term(input logic [1:0] c);
        return 3'h1 << c;
    endfunction
    task automatic end_sim;
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Waits on busy so that the next request never lands while busy.
    task automatic send(input logic three, input logic [12:0] v);
        int n;
        n = 0;
        setReq <= 1'b1;
        selectThree <= three;
        fieldValue <= v;
        @(posedge clk_sys);
        setReq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        while (busy === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (8) @(posedge clk_sys);
    endtask
    initial begin
        logic [12:0] v;
        logic [3:0] wcd;
        logic [7:0] et;
        void'($urandom(41051));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(8'(writeCasDelay), 8'h05);
        chk(8'(termSelect), 8'h01);
        chk(retainedBanks, 8'hff);
        chk(8'(busy), 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = 13'($urandom);
            v[10:9] = 2'(i % 3);
            v[5:3] = 3'(i % 5);
            wcd = 4'h5 + 4'(v[5:3]);
            hotCase <= 1'($urandom);
            addedLatency <= 2'($urandom);
            nomTermEnable <= 1'($urandom);
            selfRefresh <= 1'($urandom);
            send(1'b0, v);
            chk(8'(writeCasDelay), 8'(wcd));
            chk(8'(totalWriteDelay), 8'(wcd) + 8'(addedLatency));
            et = nomTermEnable ? 8'h00 : 8'h01;
            if (v[10:9] != 2'h0)
                et = 8'(exp_term(v[10:9]));
            chk(8'(termSelect), et);
            chk(8'(termReserved), 8'h00);
            chk(8'(doubleRefresh), 8'(v[7] | hotCase));
            chk(8'(refreshHalved), 8'(hotCase));
            chk(retainedBanks, selfRefresh ? keepTab[v[2:0]] : 8'hff);
            chk(8'(latencyReserved), 8'h00);
            chk(8'(codeRefused), 8'h00);
        end
        send(1'b0, 13'h0200);
        wcd = 4'h5;
        chk(8'(termSelect), 8'h02);
        nomTermEnable <= 1'b1;
        writeLeveling <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(8'(termSelect), 8'h00);
        writeLeveling <= 1'b0;
        writeBurst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(8'(termSelect), 8'h00);
        writeBurst <= 1'b1;
        nomTermEnable <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(8'(termSelect), 8'h02);
        foreach (keepTab[i]) begin
            if (i < 2) begin
                send(1'b0, i == 0 ? 13'h0028 : 13'h0600);
                chk(8'(codeRefused), 8'h01);
                chk(8'(writeCasDelay), 8'(wcd));
            end
        end
        for (int i = 0; i < 6; i++) begin
            v = 13'($urandom);
            v[2] = 1'(i);
            send(1'b1, v);
            chk(8'(readoutEnable), 8'(v[2]));
            chk(8'(readoutLocation), v[2] ? 8'(v[1:0]) : 8'h00);
            chk(readoutPattern, v[2] ? 8'h55 : 8'h00);
            chk(8'(writeCasDelay), 8'(wcd));
        end
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule
